// ===== dv/aux_pad_model.sv
/*
  far-side pad model for the auxiliary pins.
  assumes block pad enables and bench-chosen external drive.
*/
`timescale 1ns/100ps
`default_nettype none
module aux_pad_model
(
  input  wire logic       sys_clk,
  input  wire logic [4:0] dut_out,
  input  wire logic [4:0] dut_oe,
  input  wire logic [4:0] ext_val,
  input  wire logic [4:0] ext_en,
  output logic [4:0]      pad
);
  // undriven pins toggle so a stale level never looks valid;
  // contention is not modelled, the block wins
  logic [4:0] float_q = 5'h0a;
  always_ff @(posedge sys_clk)
    float_q <= ~float_q;
  assign pad = (dut_oe & dut_out) | (~dut_oe & ext_en & ext_val)
             | (~dut_oe & ~ext_en & float_q);
endmodule // aux_pad_model
`default_nettype wire

// ===== dv/aux_pin_function_select_tb_top.sv
/*
  self-checking bench for the auxiliary pin function block.
  assumes the pad model on the pins and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module aux_pin_function_select_tb_top;
  import aux_pin_pkg::*;
  logic        sys_clk = 1'b0, nrst = 1'b0;
  bus_req_t    bus = '0;
  logic [15:0] rdata, d;
  logic [4:0]  aux_pin_in, aux_pin_out, aux_pin_oe;
  logic [4:0]  ext_val = 5'h00, ext_en = 5'h00;
  logic        tdm_clock_master = 1'b0, alternate_clock_master = 1'b0;
  logic        msg_channel_io_drive = 1'b0, msg_channel_io_drive_en = 1'b0;
  logic        msg_channel_rx_out = 1'b0, msg_channel_clock_out = 1'b0;
  logic        timestamp_valid_out = 1'b0, timestamp_data = 1'b0;
  logic        clock_fail_status, clock_master_active, network_clock_in;
  logic        msg_channel_io_level, msg_channel_tx_in;
  int          fail_count = 0, n_checks = 0;
  aux_pin_function_select i_dut (.sys_clk, .nrst, .bus, .rdata,
    .aux_pin_in, .aux_pin_out, .aux_pin_oe, .tdm_clock_master,
    .alternate_clock_master, .clock_fail_status, .clock_master_active,
    .msg_channel_io_drive, .msg_channel_io_drive_en, .msg_channel_io_level,
    .msg_channel_tx_in, .msg_channel_rx_out, .msg_channel_clock_out,
    .network_clock_in, .timestamp_valid_out, .timestamp_data);
  aux_pad_model i_pads (.sys_clk, .dut_out(aux_pin_out), .dut_oe(aux_pin_oe),
    .ext_val, .ext_en, .pad(aux_pin_in));
  initial
    forever #50 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [15:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  task automatic wr(input logic [15:0] a, v);
    @(posedge sys_clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) bus.wr <= 1'b0;
    tick(2);
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk) bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk) bus.rd <= 1'b0;
    #10;
    d = rdata;
  endtask
  task automatic t_reset();
    // look after the launch edge has settled, not inside its time step
    #10;
    chk("oe", 16'h0000, {11'h000, aux_pin_oe});
    rd(ADDR_FUNC_SELECT);
    chk("select", FUNC_SELECT_RESET, d);
    $display("reset test done");
  endtask
  task automatic t_gpio();
    for (int p = 0; p < 5; p++)
    begin
      wr(ADDR_FUNC_SELECT, 16'hf800 | (16'h0001 << (2 * p)));
      chk("gpio oe", 16'h0001 << p, {11'h000, aux_pin_oe});
      chk("gpio out", 16'h0001 << p, {11'h000, aux_pin_out & aux_pin_oe});
    end
    wr(ADDR_FUNC_SELECT, 16'h5155);
    chk("levels", 16'h000a, {11'h000, aux_pin_out});
    rd(ADDR_FUNC_SELECT);
    chk("readback", 16'h5155, d);
    @(posedge sys_clk) {ext_en, ext_val} <= {5'h1f, 5'h0b};
    wr(ADDR_FUNC_SELECT, 16'hf800);
    chk("input oe", 16'h0000, {11'h000, aux_pin_oe});
    rd(ADDR_STATUS);
    chk("pin levels", 16'h000b, {12'h000, d[14:11]});
    $display("gpio test done");
  endtask
  task automatic t_clock_fail();
    wr(ADDR_FUNC_SELECT, 16'h0003);
    @(posedge sys_clk) {tdm_clock_master, ext_en} <= {1'b1, 5'h00};
    tick(2);
    chk("master", 16'h0005,
        {13'h0, aux_pin_oe[0], aux_pin_out[0], clock_master_active});
    @(posedge sys_clk) {tdm_clock_master, alternate_clock_master,
                        ext_en, ext_val} <= {2'b01, 5'h01, 5'h01};
    tick(4);
    chk("takeover", 16'h0003,
        {13'h0, aux_pin_oe[0], clock_fail_status, clock_master_active});
    rd(ADDR_STATUS);
    chk("status flags", 16'h0005, {13'h0, d[2:0]});
    @(posedge sys_clk) ext_val <= 5'h00;
    tick(3);
    chk("fail gone", 16'h0000,
        {14'h0, clock_fail_status, clock_master_active});
    @(posedge sys_clk) ext_val <= 5'h01;
    wr(ADDR_FUNC_SELECT, 16'h0000);
    chk("alt unused", 16'h0000, {15'h0, clock_master_active});
    @(posedge sys_clk) alternate_clock_master <= 1'b0;
    $display("clock fail test done");
  endtask
  task automatic t_msg();
    @(posedge sys_clk) {msg_channel_io_drive, msg_channel_io_drive_en,
                        msg_channel_rx_out} <= 3'b111;
    wr(ADDR_FUNC_SELECT, 16'h02a8);
    chk("io oe", 16'h001a, {11'h000, aux_pin_oe});
    chk("io out", 16'h000a, {11'h000, aux_pin_out & aux_pin_oe});
    @(posedge sys_clk) {msg_channel_io_drive_en, msg_channel_clock_out,
                        ext_en, ext_val} <= {2'b01, 5'h06, 5'h06};
    tick(3);
    chk("rx drive", 16'h0018, {11'h000, aux_pin_oe & aux_pin_out});
    chk("io in", 16'h0003, {14'h0, msg_channel_io_level, msg_channel_tx_in});
    $display("message channel test done");
  endtask
  task automatic t_srts();
    @(posedge sys_clk) {timestamp_valid_out, ext_en, ext_val} <= {1'b1, 10'h042};
    wr(ADDR_FUNC_SELECT, 16'h00fc);
    chk("ts oe", 16'h000c, {11'h000, aux_pin_oe});
    chk("ts out", 16'h0005, {12'h0, aux_pin_out[3:2], 1'b0, network_clock_in});
    @(posedge sys_clk) {timestamp_valid_out, timestamp_data} <= 2'b01;
    tick(2);
    chk("ts swap", 16'h0002, {14'h0, aux_pin_out[3:2]});
    $display("time stamp test done");
  endtask
  task automatic t_bus();
    wr(ADDR_STATUS, 16'hffff);
    rd(ADDR_FUNC_SELECT);
    chk("status write", 16'h00fc, d);
    rd(16'h6006);
    chk("unmapped", 16'h0000, d);
    @(posedge sys_clk) bus <= '{addr: ADDR_FUNC_SELECT, wdata: 16'h0155,
                               wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk) {bus.wr, bus.rd} <= 2'b01;
    @(posedge sys_clk) bus.rd <= 1'b0;
    #10;
    chk("write then read", 16'h0155, rdata);
    // read data must drop back once its one cycle is over
    tick(1);
    chk("read data drops", 16'h0000, rdata);
    $display("bus test done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #1000000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_gpio();
    t_clock_fail();
    t_msg();
    t_srts();
    t_bus();
    complete_run();
  end
endmodule // aux_pin_function_select_tb_top
`default_nettype wire

// ===== dv/aux_pin_sva.sv
/*
  port assertions for the auxiliary pin function block.
  assumes it is bound onto that block and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none
module aux_pin_sva
  import aux_pin_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  nrst,
  input wire aux_pin_pkg::bus_req_t bus,
  input wire logic [15:0]           rdata,
  input wire logic [4:0]            aux_pin_in,
  input wire logic [4:0]            aux_pin_out,
  input wire logic [4:0]            aux_pin_oe,
  input wire logic                  tdm_clock_master,
  input wire logic                  alternate_clock_master,
  input wire logic                  clock_fail_status,
  input wire logic                  clock_master_active,
  input wire logic                  msg_channel_io_drive_en,
  input wire logic                  msg_channel_io_level,
  input wire logic                  msg_channel_tx_in,
  input wire logic                  msg_channel_rx_out,
  input wire logic                  timestamp_valid_out
);
  // shadow of the select register, rebuilt from bus writes
  logic [15:0]      sel_q;
  wire  logic       sel_wr = bus.wr && bus.addr == ADDR_FUNC_SELECT;
  wire  logic [1:0] fa = sel_q[1:0];
  wire  logic [1:0] fb = sel_q[3:2];
  wire  logic [1:0] fc = sel_q[5:4];
  wire  logic [1:0] fd = sel_q[7:6];
  always_ff @(posedge sys_clk)
    sel_q <= !nrst ? FUNC_SELECT_RESET : (sel_wr ? bus.wdata : sel_q);
  default clocking cb @(posedge sys_clk); endclocking
  sequence s_sel_rd; bus.rd && bus.addr == ADDR_FUNC_SELECT; endsequence
  sequence s_wr_rd; sel_wr ##1 s_sel_rd; endsequence
  // three cycles so a registered fail level has reached the master flag
  sequence s_alt_fail;
    (!tdm_clock_master && alternate_clock_master && fa == 2'h3
     && aux_pin_in[0]) [*3];
  endsequence
  chk_reset_quiet: assert property
    (!nrst |=> aux_pin_oe == 5'h00 && rdata == 16'h0000) else $error("rst");
  for (genvar p = 0; p < 5; p++)
  begin : g_pin
    chk_gpio_input: assert property
      (disable iff (!nrst) sel_q[2*p+:2] == 2'h0 |=> !aux_pin_oe[p])
      else $error("gpio in");
    chk_gpio_output: assert property
      (disable iff (!nrst) sel_q[2*p+:2] == 2'h1 |=> aux_pin_oe[p]
       && aux_pin_out[p] == $past(sel_q[11+p])) else $error("gpio out");
  end
  chk_fail_line_drive: assert property (disable iff (!nrst)
    fa == 2'h3 && tdm_clock_master |=> aux_pin_oe[0] && !aux_pin_out[0])
    else $error("fail line drive");
  chk_fail_line_in: assert property (disable iff (!nrst)
    fa == 2'h3 && !tdm_clock_master && !alternate_clock_master |=>
    !aux_pin_oe[0] && clock_fail_status == $past(aux_pin_in[0]))
    else $error("fail line in");
  chk_alt_takeover: assert property (disable iff (!nrst)
    s_alt_fail |-> clock_master_active) else $error("alt take");
  chk_master_idle: assert property (disable iff (!nrst)
    !tdm_clock_master && (!alternate_clock_master || fa != 2'h3)
    |=> !clock_master_active) else $error("alt idle");
  chk_msg_line: assert property (disable iff (!nrst) fb == 2'h2
    |=> aux_pin_oe[1] == $past(msg_channel_io_drive_en)
    && msg_channel_io_level == $past(aux_pin_in[1])) else $error("msg line");
  chk_msg_tx: assert property (disable iff (!nrst) fc == 2'h2
    |=> !aux_pin_oe[2] && msg_channel_tx_in == $past(aux_pin_in[2]))
    else $error("msg tx");
  chk_stamp_enable: assert property (disable iff (!nrst) fc == 2'h3
    |=> aux_pin_oe[2] && aux_pin_out[2] == $past(timestamp_valid_out))
    else $error("ts en");
  chk_msg_rx: assert property (disable iff (!nrst) fd == 2'h2
    |=> aux_pin_oe[3] && aux_pin_out[3] == $past(msg_channel_rx_out))
    else $error("msg rx");
  chk_read_back: assert property (disable iff (!nrst)
    s_wr_rd |=> rdata == $past(bus.wdata, 2)) else $error("readback");
endmodule // aux_pin_sva
bind aux_pin_function_select aux_pin_sva i_sva (.sys_clk, .nrst, .bus,
  .rdata, .aux_pin_in, .aux_pin_out, .aux_pin_oe, .tdm_clock_master,
  .alternate_clock_master, .clock_fail_status, .clock_master_active,
  .msg_channel_io_drive_en, .msg_channel_io_level, .msg_channel_tx_in,
  .msg_channel_rx_out, .timestamp_valid_out);
`default_nettype wire

// ===== inc/aux_pin_pkg.sv
/*
  shared constants, types and helpers of the auxiliary pin function block.
  assumes a 16-bit register port with addresses as printed for the device.
*/
`default_nettype none
package aux_pin_pkg;

  localparam int unsigned NUM_PINS = 5;
  localparam int unsigned PIN_A    = 0;
  localparam int unsigned PIN_B    = 1;
  localparam int unsigned PIN_C    = 2;
  localparam int unsigned PIN_D    = 3;
  localparam int unsigned PIN_E    = 4;

  localparam logic [15:0] ADDR_STATUS       = 16'h6002;
  localparam logic [15:0] ADDR_FUNC_SELECT  = 16'h6004;
  localparam logic [15:0] FUNC_SELECT_RESET = 16'h0000;

  localparam int unsigned FN_FIELD_W     = 2;
  localparam int unsigned VALUE_LSB      = 11;
  localparam int unsigned RESERVED_BIT   = 10;
  localparam int unsigned STAT_LEVEL_LSB = 11;
  localparam int unsigned STAT_LEVELS    = 4;
  localparam int unsigned STAT_FAIL_BIT  = 0;
  localparam int unsigned STAT_CFGER_BIT = 1;
  localparam int unsigned STAT_MASTER_BIT = 2;

  typedef enum logic [1:0] {
    FN_INPUT  = 2'h0,
    FN_OUTPUT = 2'h1,
    FN_ALT1   = 2'h2,
    FN_ALT2   = 2'h3
  } fn_code_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe;
  } pin_drive_t;

  function automatic fn_code_t pin_fn(input logic [15:0] sel,
                                      input int unsigned pin);
    logic [1:0] f;
    f = sel[pin*FN_FIELD_W +: FN_FIELD_W];
    return fn_code_t'(f);
  endfunction

  function automatic logic pin_value(input logic [15:0] sel,
                                     input int unsigned pin);
    return sel[VALUE_LSB + pin];
  endfunction

endpackage
`default_nettype wire

// ===== rtl/aux_level_sampler.sv
/*
  samples the auxiliary pad levels once per clock for status reads.
  assumes pad inputs are synchronous to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module aux_level_sampler
  import aux_pin_pkg::*;
(
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  wire logic [aux_pin_pkg::NUM_PINS-1:0] pin_in,
  output logic [aux_pin_pkg::NUM_PINS-1:0]   level
);
  import aux_pin_pkg::*;

  typedef struct packed {
    logic [NUM_PINS-1:0] level;
  } sampler_state_t;

  sampler_state_t s_q;
  sampler_state_t s_d;

  always_comb
  begin
    s_d       = s_q;
    s_d.level = pin_in;
  end

  // levels are undefined after reset by contract; zero keeps sims clean
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign level = s_q.level;

endmodule // aux_level_sampler
`default_nettype wire

// ===== rtl/aux_pin_drive.sv
/*
  per-pin output selector: picks drive level and enable from the function code.
  assumes the caller registers the result before it reaches the pad.
*/
`timescale 1ns/100ps
`default_nettype none
module aux_pin_drive
  import aux_pin_pkg::*;
(
  input  wire aux_pin_pkg::fn_code_t fn,
  input  wire logic                  value,
  input  wire logic                  alt1_out,
  input  wire logic                  alt1_oe,
  input  wire logic                  alt2_out,
  input  wire logic                  alt2_oe,
  output logic                       out,
  output logic                       oe
);
  import aux_pin_pkg::*;

  always_comb
  begin
    out = 1'b0;
    oe  = 1'b0;
    case (fn)
      FN_INPUT:
      begin
        out = 1'b0;
        oe  = 1'b0;
      end
      FN_OUTPUT:
      begin
        out = value;
        oe  = 1'b1;
      end
      FN_ALT1:
      begin
        out = alt1_out;
        oe  = alt1_oe;
      end
      FN_ALT2:
      begin
        out = alt2_out;
        oe  = alt2_oe;
      end
      default:
      begin
        out = 1'b0;
        oe  = 1'b0;
      end
    endcase
  end

endmodule // aux_pin_drive
`default_nettype wire

// ===== rtl/aux_pin_function_select.sv
/*
  function selection for five auxiliary multi-function pins, with the
  software register that picks each role and the levels for output mode.
  assumes a one-clock register port, an external message-channel
  controller, an external time-stamp clock recovery engine, and the clock
  master / alternate settings coming from the bus type register elsewhere.
*/
// Design decision made here: the strobed register port.
// Contract
// - select register resets to zero: all pins inputs, output levels low.
// - five two-bit select fields, pin a at bits 1:0 up to pin e at 9:8.
// - code 00 makes a pin an input, 01 a programmable output.
// - bits 11..15 give levels for pins a..e, used only under code 01.
// - pin a code 11: drive low as clock master, else clock-fail input.
// - pin b code 10: message line; receive out on d, transmit from c.
// - pin b code 11: network clock input for time-stamp logic.
// - pin c code 10: message channel transmit data input.
// - pin c code 11: enable output while valid time-stamp bit goes on d.
// - pin d code 10: drives message channel receive data.
// - pin d code 11: drives serial time-stamp data.
// - pin e code 10: drives message channel clock.
// - status bits 11..14 show live levels of pins a..d.
// - alternate master takes over clocks only while clock-fail is high.
`timescale 1ns/100ps
`default_nettype none
module aux_pin_function_select
  import aux_pin_pkg::*;
(
  input  wire logic                             sys_clk,
  input  wire logic                             nrst,
  input  wire aux_pin_pkg::bus_req_t            bus,
  output logic [15:0]                           rdata,
  input  wire logic [aux_pin_pkg::NUM_PINS-1:0] aux_pin_in,
  output logic [aux_pin_pkg::NUM_PINS-1:0]      aux_pin_out,
  output logic [aux_pin_pkg::NUM_PINS-1:0]      aux_pin_oe,
  input  wire logic                             tdm_clock_master,
  input  wire logic                             alternate_clock_master,
  output logic                                  clock_fail_status,
  output logic                                  clock_master_active,
  input  wire logic                             msg_channel_io_drive,
  input  wire logic                             msg_channel_io_drive_en,
  output logic                                  msg_channel_io_level,
  output logic                                  msg_channel_tx_in,
  input  wire logic                             msg_channel_rx_out,
  input  wire logic                             msg_channel_clock_out,
  output logic                                  network_clock_in,
  input  wire logic                             timestamp_valid_out,
  input  wire logic                             timestamp_data
);
  import aux_pin_pkg::*;

  typedef struct packed {
    logic [15:0]         sel;
    logic [15:0]         rdata;
    pin_drive_t          pins;
    logic                clk_fail;
    logic                master;
    logic                msg_level;
    logic                msg_tx;
    logic                net_clk;
  } top_state_t;

  localparam top_state_t STATE_RESET = '{
    sel:      FUNC_SELECT_RESET,
    rdata:    16'h0000,
    pins:     '0,
    clk_fail:  1'b0,
    master:    1'b0,
    msg_level: 1'b0,
    msg_tx:    1'b0,
    net_clk:  1'b0
  };

  top_state_t s_q;
  top_state_t s_d;

  fn_code_t            fn_a;
  fn_code_t            fn_b;
  fn_code_t            fn_c;
  fn_code_t            fn_d;
  fn_code_t            fn_e;
  logic [NUM_PINS-1:0] alt1_out;
  logic [NUM_PINS-1:0] alt1_oe;
  logic [NUM_PINS-1:0] alt2_out;
  logic [NUM_PINS-1:0] alt2_oe;
  pin_drive_t          drive;
  logic [NUM_PINS-1:0] level;
  logic                cfg_error;
  logic [15:0]         status_word;

  // field decode of the select register
  always_comb
  begin
    fn_a = pin_fn(s_q.sel, PIN_A);
    fn_b = pin_fn(s_q.sel, PIN_B);
    fn_c = pin_fn(s_q.sel, PIN_C);
    fn_d = pin_fn(s_q.sel, PIN_D);
    fn_e = pin_fn(s_q.sel, PIN_E);
  end

  // alternate-function drive sources per pin; any oe low leaves the pad
  // floating so the far end or a pull resistor sets the level
  always_comb
  begin
    alt1_out = '0;
    alt1_oe  = '0;
    alt2_out = '0;
    alt2_oe  = '0;
    // pin a: code 10 unused, stays undriven; code 11 pulls low as master
    alt2_out[PIN_A] = 1'b0;
    alt2_oe[PIN_A]  = tdm_clock_master;
    // pin b: shared message line, controller owns its direction
    alt1_out[PIN_B] = msg_channel_io_drive;
    alt1_oe[PIN_B]  = msg_channel_io_drive_en;
    alt2_oe[PIN_B]  = 1'b0;
    // pin c: transmit data in, or time-stamp enable out
    alt1_oe[PIN_C]  = 1'b0;
    alt2_out[PIN_C] = timestamp_valid_out;
    alt2_oe[PIN_C]  = 1'b1;
    // pin d: receive data out, or serial time-stamp data out
    alt1_out[PIN_D] = msg_channel_rx_out;
    alt1_oe[PIN_D]  = 1'b1;
    alt2_out[PIN_D] = timestamp_data;
    alt2_oe[PIN_D]  = 1'b1;
    // pin e: message clock out; code 11 unused, stays undriven
    alt1_out[PIN_E] = msg_channel_clock_out;
    alt1_oe[PIN_E]  = 1'b1;
    alt2_oe[PIN_E]  = 1'b0;
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++)
    begin : g_pin
      aux_pin_drive u_drive (
        .fn       (pin_fn(s_q.sel, gp)),
        .value    (pin_value(s_q.sel, gp)),
        .alt1_out (alt1_out[gp]),
        .alt1_oe  (alt1_oe[gp]),
        .alt2_out (alt2_out[gp]),
        .alt2_oe  (alt2_oe[gp]),
        .out      (drive.out[gp]),
        .oe       (drive.oe[gp])
      );
    end
  endgenerate

  aux_level_sampler u_levels (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin_in  (aux_pin_in),
    .level   (level)
  );

  // flags a select value software should never program
  always_comb
  begin
    cfg_error = (fn_a == FN_ALT1) || (fn_e == FN_ALT2)
              || s_q.sel[RESERVED_BIT];
  end

  always_comb
  begin
    status_word = 16'h0000;
    status_word[STAT_LEVEL_LSB +: STAT_LEVELS] =
      level[STAT_LEVELS-1:0];
    status_word[STAT_FAIL_BIT]   = s_q.clk_fail;
    status_word[STAT_CFGER_BIT]  = cfg_error;
    status_word[STAT_MASTER_BIT] = s_q.master;
  end

  always_comb
  begin
    s_d = s_q;

    // register port: write stores the whole word, bit 10 included
    if (bus.wr && (bus.addr == ADDR_FUNC_SELECT))
      s_d.sel = bus.wdata;

    // read data stands only in the cycle after the strobe
    s_d.rdata = 16'h0000;
    if (bus.rd)
    begin
      case (bus.addr)
        ADDR_FUNC_SELECT: s_d.rdata = s_q.sel;
        ADDR_STATUS:      s_d.rdata = status_word;
        default:          s_d.rdata = 16'h0000;
      endcase
    end

    // pad drive registered so pads change only on clock edges
    s_d.pins = drive;

    // clock-fail line is only meaningful in its own mode; while we are
    // master we pull it low ourselves, so its level reads back as no-fail
    s_d.clk_fail = (fn_a == FN_ALT2) && aux_pin_in[PIN_A];

    // alternate master takes over only while the fail status is high
    s_d.master = tdm_clock_master
               || (alternate_clock_master && (fn_a == FN_ALT2)
                   && s_q.clk_fail);

    // inbound pad levels routed to their consumers only in their mode
    s_d.msg_level = (fn_b == FN_ALT1) && aux_pin_in[PIN_B];
    s_d.msg_tx    = (fn_c == FN_ALT1) && aux_pin_in[PIN_C];
    s_d.net_clk  = (fn_b == FN_ALT2) && aux_pin_in[PIN_B];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      s_q <= STATE_RESET;
    else
      s_q <= s_d;
  end

  assign rdata                = s_q.rdata;
  assign aux_pin_out          = s_q.pins.out;
  assign aux_pin_oe           = s_q.pins.oe;
  assign clock_fail_status    = s_q.clk_fail;
  assign clock_master_active  = s_q.master;
  assign msg_channel_io_level = s_q.msg_level;
  assign msg_channel_tx_in    = s_q.msg_tx;
  assign network_clock_in     = s_q.net_clk;

endmodule // aux_pin_function_select
`default_nettype wire
